//--- core/acp_consts.svh
`ifndef ACP_CONSTS_SVH
`define ACP_CONSTS_SVH
// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define ACP_OFS_CFG 8'h00
`define ACP_OFS_CTRL 8'h04
`define ACP_OFS_STAT 8'h08
`define ACP_CFG_ADDR 7:0
`define ACP_CFG_TYPE 15:8
`define ACP_CFG_BAUD 23:16
`define ACP_CFG_FMT 31:24
`define ACP_FMT_CKS_BIT 30
`define ACP_RST_CFG 32'h0006_0000
`define ACP_RST_CHAN 4'hf
// ----------------------------------------
// characters
// ----------------------------------------
`define ACP_CH_LEAD 8'h24
`define ACP_CH_ACK 8'h21
`define ACP_CH_NAK 8'h3f
`define ACP_CH_CR 8'h0d
`define ACP_CH_ZERO 8'h30
`define ACP_CH_ONE 8'h31
`define ACP_CMD_CFG 8'h32
`define ACP_CMD_OFS 8'h31
`define ACP_CMD_GAIN 8'h30
`define ACP_CMD_NAME 8'h4d
`define ACP_CMD_CHEN 8'h35
`define ACP_CMD_CHST 8'h36
`define ACP_CMD_PROT 8'h50
`endif

//--- core/acp_pkg.sv
package acp_pkg;
    typedef enum logic [6:0] {
        ST_HUNT = 7'b0000001,
        ST_COLLECT = 7'b0000010,
        ST_DECODE = 7'b0000100,
        ST_SEND = 7'b0001000,
        ST_CKH = 7'b0010000,
        ST_CKL = 7'b0100000,
        ST_END = 7'b1000000
    } acp_state_t;
endpackage

//--- core/acp_hex.sv
`timescale 1ns/10ps
`include "acp_consts.svh"
module acp_hex (
    input wire logic [7:0] ch,
    output logic [3:0] nib,
    output logic ok
);
    // upper case only: lower-case letters never match
    always_comb
    begin
        nib = 4'h0;
        ok = 1'b0;
        if (ch >= 8'h30 && ch <= 8'h39)
        begin
            nib = ch[3:0];
            ok = 1'b1;
        end
        else if (ch >= 8'h41 && ch <= 8'h46)
        begin
            nib = ch[3:0] + 4'h9;
            ok = 1'b1;
        end
    end
endmodule // acp_hex

//--- core/acp_parser.sv
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
`include "acp_consts.svh"
// Function
// - $AA2 cr reads back address, type code, baud code and format byte
// - syntax, checksum, overflow or foreign address: no reply at all
// - addressed but invalid command replies ?AA cr
// - $AA1N cr pulses offset calibration of channel N, replies !AA cr
// - $AA0N cr pulses gain calibration of channel N, replies !AA cr
// - $AAM cr replies !AA, stored module name, cr
// - $AA50V cr loads channel enables from low bits of V
// - $AA6 cr replies !AA0V cr with channel enable bits
// - $AAPV cr selects ascii (0) or modbus rtu (1)
// - protocol select applied only in default configuration state
// - every frame ends in carriage return 0dh
// - two hex address characters compared with own address
// - checksum: two hex chars before cr, sum of prior chars and 0xff
// - format bit 6 enables checksum, bits 1..0 data format
module acp_parser
    import acp_pkg::*;
#(
    parameter int NCH = 4,
    parameter int NAME_LEN = 6,
    // arbitrary neutral name value
    parameter logic [8*NAME_LEN-1:0] MODULE_NAME = "ACQ4CH"
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic cal_offset_pulse,
    output logic cal_gain_pulse,
    output logic [$clog2(NCH)-1:0] cal_chan,
    output logic [NCH-1:0] chan_enable,
    output logic proto_modbus
);
    localparam int RX_MAX = 8;
    localparam int TX_MAX = 16;
    localparam int CW = $clog2(NCH);

    function automatic logic [7:0] to_hex(input logic [3:0] n);
        return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

    // ----------------------------------------
    // ahb-lite slave
    // ----------------------------------------
    logic ap_valid_reg;
    logic ap_write_reg;
    logic [7:0] ap_addr_reg;
    logic rd_done_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] cfg_reg;
    logic cfg_state_reg;
    logic [15:0] frame_cnt_reg;
    logic [NCH-1:0] chan_en_reg;
    logic proto_reg;
    logic rd_stall;
    logic [31:0] rd_mux;

    // reads take one wait state so a write just before is seen
    assign rd_stall = ap_valid_reg & ~ap_write_reg & ~rd_done_reg;
    assign hreadyout = ~rd_stall;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg <= 8'h00;
        end
        else if (hready)
        begin
            ap_valid_reg <= hsel & htrans[1];
            ap_write_reg <= hwrite;
            ap_addr_reg <= haddr[7:0];
        end
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (ap_addr_reg)
            `ACP_OFS_CFG: rd_mux = cfg_reg;
            `ACP_OFS_CTRL: rd_mux = {31'h0, cfg_state_reg};
            `ACP_OFS_STAT:
            begin
                rd_mux[NCH-1:0] = chan_en_reg;
                rd_mux[8] = proto_reg;
                rd_mux[31:16] = frame_cnt_reg;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_done_reg <= 1'b0;
            hrdata_reg <= 32'h0000_0000;
        end
        else
        begin
            rd_done_reg <= rd_stall;
            if (rd_stall)
                hrdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_reg <= `ACP_RST_CFG;
            cfg_state_reg <= 1'b0;
        end
        else if (ap_valid_reg && ap_write_reg && hready)
        begin
            if (ap_addr_reg == `ACP_OFS_CFG)
                cfg_reg <= hwdata;
            if (ap_addr_reg == `ACP_OFS_CTRL)
                cfg_state_reg <= hwdata[0];
        end
    end

    // ----------------------------------------
    // receive and frame collection
    // ----------------------------------------
    acp_state_t state_reg;
    logic [7:0] rx_buf [RX_MAX];
    logic [3:0] rx_cnt_reg;
    logic [7:0] sum_reg;
    logic ovf_reg;
    logic rx_fire;
    logic ck_en;

    assign ck_en = cfg_reg[`ACP_FMT_CKS_BIT];
    // the modbus engine owns the line once selected
    assign rx_ready = (state_reg == ST_HUNT || state_reg == ST_COLLECT)
        && !proto_reg;
    assign rx_fire = rx_valid & rx_ready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_cnt_reg <= 4'h0;
            sum_reg <= 8'h00;
            ovf_reg <= 1'b0;
            for (int i = 0; i < RX_MAX; i++)
                rx_buf[i] <= 8'h00;
        end
        else if (rx_fire)
        begin
            if (rx_data == `ACP_CH_LEAD)
            begin
                rx_cnt_reg <= 4'h0;
                sum_reg <= `ACP_CH_LEAD;
                ovf_reg <= 1'b0;
            end
            else if (state_reg == ST_COLLECT && rx_data != `ACP_CH_CR)
            begin
                if (rx_cnt_reg == 4'(RX_MAX))
                    ovf_reg <= 1'b1;
                else
                begin
                    rx_buf[rx_cnt_reg[2:0]] <= rx_data;
                    rx_cnt_reg <= rx_cnt_reg + 4'h1;
                    sum_reg <= sum_reg + rx_data;
                end
            end
        end
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic [7:0] h_in [6];
    logic [3:0] h_nib [6];
    logic h_ok [6];
    logic [3:0] ckh_idx;
    logic [3:0] ckl_idx;
    logic [3:0] bl;
    logic [7:0] cmd;
    logic [7:0] body_sum;
    logic d_len_ok;
    logic d_addr_ok;
    logic d_ck_ok;
    logic d_match;
    logic d_reply;
    logic d_cfg;
    logic d_ofs;
    logic d_gain;
    logic d_name;
    logic d_chen;
    logic d_chst;
    logic d_prot;
    logic d_ack;
    logic d_cal_ok;

    assign ckh_idx = rx_cnt_reg - 4'h2;
    assign ckl_idx = rx_cnt_reg - 4'h1;
    assign h_in[0] = rx_buf[0];
    assign h_in[1] = rx_buf[1];
    assign h_in[2] = rx_buf[3];
    assign h_in[3] = rx_buf[4];
    assign h_in[4] = rx_buf[ckh_idx[2:0]];
    assign h_in[5] = rx_buf[ckl_idx[2:0]];

    generate
        for (genvar g = 0; g < 6; g++)
        begin : g_hex
            acp_hex u_hex (
                .ch(h_in[g]),
                .nib(h_nib[g]),
                .ok(h_ok[g])
            );
        end
    endgenerate

    assign bl = ck_en ? ckh_idx : rx_cnt_reg;
    assign cmd = rx_buf[2];
    assign body_sum = sum_reg - rx_buf[ckh_idx[2:0]] - rx_buf[ckl_idx[2:0]];
    assign d_len_ok = ck_en ? (rx_cnt_reg >= 4'h5) : (rx_cnt_reg >= 4'h3);
    assign d_addr_ok = h_ok[0] & h_ok[1];
    assign d_ck_ok = !ck_en || (h_ok[4] && h_ok[5]
        && {h_nib[4], h_nib[5]} == body_sum);
    assign d_match = {h_nib[0], h_nib[1]} == cfg_reg[`ACP_CFG_ADDR];
    assign d_reply = !ovf_reg && d_len_ok && d_addr_ok && d_ck_ok
        && d_match;
    assign d_cal_ok = (bl == 4'h4) && h_ok[2]
        && (h_nib[2] < 4'(NCH));
    assign d_cfg = (cmd == `ACP_CMD_CFG) && (bl == 4'h3);
    assign d_ofs = (cmd == `ACP_CMD_OFS) && d_cal_ok;
    assign d_gain = (cmd == `ACP_CMD_GAIN) && d_cal_ok;
    assign d_name = (cmd == `ACP_CMD_NAME) && (bl == 4'h3);
    assign d_chen = (cmd == `ACP_CMD_CHEN) && (bl == 4'h5)
        && (rx_buf[3] == `ACP_CH_ZERO) && h_ok[3];
    assign d_chst = (cmd == `ACP_CMD_CHST) && (bl == 4'h3);
    assign d_prot = (cmd == `ACP_CMD_PROT) && (bl == 4'h4) && cfg_state_reg
        && (rx_buf[3] == `ACP_CH_ZERO || rx_buf[3] == `ACP_CH_ONE);
    assign d_ack = d_cfg | d_ofs | d_gain | d_name | d_chen | d_chst
        | d_prot;

    // ----------------------------------------
    // control state machine and response
    // ----------------------------------------
    logic [7:0] tx_buf [TX_MAX];
    logic [4:0] tx_len_reg;
    logic [4:0] tx_idx_reg;
    logic [4:0] idx_n;
    logic [7:0] tx_sum_reg;
    logic [7:0] tx_data_reg;
    logic [7:0] sum_n;
    logic tx_ck_reg;
    logic [3:0] chan_nib;
    logic [7:0] own_hi;
    logic [7:0] own_lo;

    assign idx_n = tx_idx_reg + 5'h1;
    assign sum_n = tx_sum_reg + tx_data_reg;
    assign own_hi = to_hex(cfg_reg[7:4]);
    assign own_lo = to_hex(cfg_reg[3:0]);
    assign tx_valid = (state_reg == ST_SEND) || (state_reg == ST_CKH)
        || (state_reg == ST_CKL) || (state_reg == ST_END);
    assign tx_data = tx_data_reg;

    always_comb
    begin
        chan_nib = 4'h0;
        chan_nib[NCH-1:0] = chan_en_reg;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_reg <= ST_HUNT;
        else
        begin
            unique case (state_reg)
                ST_HUNT:
                    if (rx_fire && rx_data == `ACP_CH_LEAD)
                        state_reg <= ST_COLLECT;
                ST_COLLECT:
                    if (rx_fire && rx_data == `ACP_CH_CR)
                        state_reg <= ST_DECODE;
                ST_DECODE:
                    state_reg <= d_reply ? ST_SEND : ST_HUNT;
                ST_SEND:
                    if (tx_ready && tx_idx_reg == tx_len_reg - 5'h1)
                        state_reg <= tx_ck_reg ? ST_CKH : ST_END;
                ST_CKH:
                    if (tx_ready)
                        state_reg <= ST_CKL;
                ST_CKL:
                    if (tx_ready)
                        state_reg <= ST_END;
                ST_END:
                    if (tx_ready)
                        state_reg <= ST_HUNT;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_len_reg <= 5'h0;
            tx_ck_reg <= 1'b0;
            for (int i = 0; i < TX_MAX; i++)
                tx_buf[i] <= 8'h00;
        end
        else if (state_reg == ST_DECODE && d_reply)
        begin
            tx_ck_reg <= ck_en;
            tx_buf[0] <= d_ack ? `ACP_CH_ACK : `ACP_CH_NAK;
            tx_buf[1] <= own_hi;
            tx_buf[2] <= own_lo;
            tx_len_reg <= 5'h3;
            if (d_cfg)
            begin
                tx_buf[3] <= to_hex(cfg_reg[15:12]);
                tx_buf[4] <= to_hex(cfg_reg[11:8]);
                tx_buf[5] <= to_hex(cfg_reg[23:20]);
                tx_buf[6] <= to_hex(cfg_reg[19:16]);
                tx_buf[7] <= to_hex(cfg_reg[31:28]);
                tx_buf[8] <= to_hex(cfg_reg[27:24]);
                tx_len_reg <= 5'h9;
            end
            else if (d_name)
            begin
                for (int i = 0; i < NAME_LEN; i++)
                    tx_buf[3+i] <= MODULE_NAME[8*(NAME_LEN-1-i) +: 8];
                tx_len_reg <= 5'(3 + NAME_LEN);
            end
            else if (d_chst)
            begin
                tx_buf[3] <= `ACP_CH_ZERO;
                tx_buf[4] <= to_hex(chan_nib);
                tx_len_reg <= 5'h5;
            end
        end
    end

    // the character on tx_data is always registered one step ahead
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_idx_reg <= 5'h0;
            tx_sum_reg <= 8'h00;
            tx_data_reg <= 8'h00;
        end
        else if (state_reg == ST_DECODE)
        begin
            tx_idx_reg <= 5'h0;
            tx_sum_reg <= 8'h00;
            tx_data_reg <= d_ack ? `ACP_CH_ACK : `ACP_CH_NAK;
        end
        else if (tx_valid && tx_ready)
        begin
            if (state_reg == ST_SEND)
            begin
                tx_sum_reg <= sum_n;
                tx_idx_reg <= idx_n;
                if (tx_idx_reg != tx_len_reg - 5'h1)
                    tx_data_reg <= tx_buf[idx_n[3:0]];
                else if (tx_ck_reg)
                    tx_data_reg <= to_hex(sum_n[7:4]);
                else
                    tx_data_reg <= `ACP_CH_CR;
            end
            else if (state_reg == ST_CKH)
                tx_data_reg <= to_hex(tx_sum_reg[3:0]);
            else if (state_reg == ST_CKL)
                tx_data_reg <= `ACP_CH_CR;
        end
    end

    // ----------------------------------------
    // command effects
    // ----------------------------------------
    logic go;

    assign go = (state_reg == ST_DECODE) && d_reply;
    assign cal_chan = h_nib[2][CW-1:0];
    assign chan_enable = chan_en_reg;
    assign proto_modbus = proto_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cal_offset_pulse <= 1'b0;
            cal_gain_pulse <= 1'b0;
            chan_en_reg <= `ACP_RST_CHAN;
            proto_reg <= 1'b0;
            frame_cnt_reg <= 16'h0000;
        end
        else
        begin
            cal_offset_pulse <= go && d_ofs;
            cal_gain_pulse <= go && d_gain;
            if (go && d_chen)
                chan_en_reg <= h_nib[3][NCH-1:0];
            if (go && d_prot)
                proto_reg <= rx_buf[3][0];
            if (go)
                frame_cnt_reg <= frame_cnt_reg + 16'h0001;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_silent_foreign: assert property (
        state_reg == ST_DECODE && !d_match |=> state_reg == ST_HUNT)
        else $error("reply to foreign address");
    a_nak_leader: assert property (
        go && !d_ack |=> tx_data == `ACP_CH_NAK && tx_valid)
        else $error("invalid command not answered with nak");
    a_cfg_len: assert property (
        go && d_cfg |=> tx_len_reg == 5'h9 && tx_buf[8] == to_hex(
        $past(cfg_reg[27:24])))
        else $error("config reply malformed");
    a_offset_once: assert property (
        cal_offset_pulse |-> $past(d_ofs) && !cal_gain_pulse
        ##1 !cal_offset_pulse)
        else $error("offset pulse wrong");
    a_gain_chan: assert property (
        cal_gain_pulse |-> $past(h_nib[2]) < 4'(NCH))
        else $error("gain pulse on bad channel");
    a_name_len: assert property (
        go && d_name |=> tx_len_reg == 5'(3 + NAME_LEN))
        else $error("name reply length wrong");
    a_chan_load: assert property (
        go && d_chen |=> chan_en_reg == $past(h_nib[3][NCH-1:0]))
        else $error("channel enable not loaded");
    a_chst_zero: assert property (
        go && d_chst |=> tx_buf[3] == `ACP_CH_ZERO)
        else $error("status reply lacks zero digit");
    a_proto_guard: assert property (
        $changed(proto_reg) |-> $past(cfg_state_reg))
        else $error("protocol changed outside default state");
    a_frame_cr: assert property (
        state_reg == ST_END |-> tx_data == `ACP_CH_CR)
        else $error("frame does not end in cr");
    a_ck_follow: assert property (
        state_reg == ST_SEND && tx_ready && tx_ck_reg
        && tx_idx_reg == tx_len_reg - 5'h1 |=> state_reg == ST_CKH
        ##0 tx_data == to_hex($past(sum_n[7:4])))
        else $error("checksum not appended");
    a_hunt_discard: assert property (
        state_reg == ST_HUNT && rx_fire && rx_data != `ACP_CH_LEAD
        |=> state_reg == ST_HUNT)
        else $error("left hunt without leader");
    a_cal_range: assert property (
        go && (cmd == `ACP_CMD_OFS) && !d_cal_ok |=> !cal_offset_pulse
        && tx_data == `ACP_CH_NAK)
        else $error("out-of-range channel accepted");

    c_cfg_read: cover property (go && d_cfg);
    c_name_ck: cover property (go && d_name && ck_en);
    c_nak: cover property (go && !d_ack);
    c_proto: cover property (go && d_prot);
endmodule // acp_parser

//--- tb/acp_host_model.sv
`timescale 1ns/10ps
// host on the far side of the character link
module acp_host_model (
    input wire logic hclk,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    logic slow = 1'b0;
    string reply = "";
    initial
    begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end
    // slow host accepts every other cycle to stall the reply
    always @(posedge hclk)
    begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            reply = $sformatf("%s%c", reply, tx_data);
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    task automatic send(input string s);
        logic r;
        s = {s, "\015"};
        for (int i = 0; i < s.len(); i++)
        begin
            rx_data <= s[i];
            rx_valid <= 1'b1;
            do
            begin
                @(negedge hclk);
                r = rx_ready;
                @(posedge hclk);
            end while (r !== 1'b1);
        end
        rx_valid <= 1'b0;
        // released line must not keep showing the cr
        rx_data <= ~rx_data;
    endtask
endmodule // acp_host_model

//--- tb/ascii_config_command_parser_tb.sv
`timescale 1ns/10ps
`include "acp_consts.svh"
module ascii_config_command_parser_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp, rx_valid, rx_ready, tx_valid, tx_ready;
    logic [31:0] hrdata, rd;
    logic [7:0] rx_data, tx_data;
    logic cal_offset_pulse, cal_gain_pulse, proto_modbus;
    logic [1:0] cal_chan, last_ch;
    logic [3:0] chan_enable;
    int err_count = 0, tests_run = 0, ofs_n = 0, gain_n = 0, rep_n = 0;
    assign hready = hreadyout;
    always #10 hclk = ~hclk;
    acp_parser uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready),
        .cal_offset_pulse(cal_offset_pulse), .cal_gain_pulse(cal_gain_pulse),
        .cal_chan(cal_chan), .chan_enable(chan_enable),
        .proto_modbus(proto_modbus));
    acp_host_model host (.hclk(hclk), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready));
    always @(posedge hclk)
    begin
        if (cal_offset_pulse === 1'b1)
            ofs_n++;
        if (cal_gain_pulse === 1'b1)
            gain_n++;
        if (cal_offset_pulse === 1'b1 || cal_gain_pulse === 1'b1)
            last_ch = cal_chan;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_str(input string got, input string exp);
        tests_run++;
        if (got != exp)
        begin
            err_count++;
            $display("unexpected at %0t: reply %s want %s", $time, got, exp);
        end
    endtask
    task automatic bus_wait;
        logic r;
        do
        begin
            @(negedge hclk);
            r = hreadyout;
            rd = hrdata;
            @(posedge hclk);
        end while (r !== 1'b1);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        bus_wait();
        htrans <= 2'b00;
        hwdata <= d;
        bus_wait();
    endtask
    // empty exp means the device must stay silent
    task automatic cmd(input string s, input string exp);
        host.reply = "";
        host.send(s);
        for (int i = 0; i < 200; i++)
        begin
            @(negedge hclk);
            if (exp == "" && i == 20)
                break;
            if (host.reply.len() > 0 &&
                host.reply[host.reply.len()-1] == 8'h0d)
                break;
        end
        if (exp != "")
        begin
            exp = {exp, "\015"};
            rep_n++;
        end
        chk_str(host.reply, exp);
        @(posedge hclk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        ahb(1'b0, `ACP_OFS_CFG, 32'h0);
        chk_val(rd, 32'h0006_0000);
        chk_val(hresp, 1'b0);
        ahb(1'b0, `ACP_OFS_STAT, 32'h0);
        chk_val(rd, 32'h0000_000f);
        ahb(1'b1, 8'h0c, 32'hffff_ffff);
        ahb(1'b0, 8'h0c, 32'h0);
        chk_val(rd, 32'h0);
    endtask
    task automatic t_frames;
        cmd("zz$9$002", "!00000600");
        cmd("$052", "");
        cmd("$0G2", "");
        cmd("$001234567", "");
        cmd("$00m", "?00");
        cmd("$00Z", "?00");
        cmd("$0029", "?00");
    endtask
    task automatic t_cal;
        cmd("$0013", "!00");
        chk_val(ofs_n, 1);
        chk_val(last_ch, 2'd3);
        cmd("$0003", "!00");
        chk_val(gain_n, 1);
        chk_val(last_ch, 2'd3);
        cmd("$0014", "?00");
        cmd("$0004", "?00");
        chk_val(ofs_n + gain_n, 2);
    endtask
    task automatic t_chan;
        cmd("$00M", "!00ACQ4CH");
        cmd("$00505", "!00");
        chk_val(chan_enable, 4'h5);
        cmd("$006", "!0005");
        cmd("$0050A", "!00");
        cmd("$006", "!000A");
    endtask
    task automatic t_cksum;
        ahb(1'b1, `ACP_OFS_CFG, 32'h4006_0002);
        host.slow = 1'b1;
        cmd("$022B8", "!02000640AD");
        cmd("$022B9", "");
        cmd("$02ZE0", "?02A1");
        host.slow = 1'b0;
        ahb(1'b1, `ACP_OFS_CFG, 32'h0006_0000);
    endtask
    // modbus selection is last: the character link then stays closed
    task automatic t_proto;
        cmd("$00P1", "?00");
        chk_val(proto_modbus, 1'b0);
        ahb(1'b1, `ACP_OFS_CTRL, 32'h1);
        cmd("$00P0", "!00");
        chk_val(proto_modbus, 1'b0);
        cmd("$00P1", "!00");
        chk_val(proto_modbus, 1'b1);
        ahb(1'b0, `ACP_OFS_STAT, 32'h0);
        chk_val(rd, {rep_n[15:0], 7'h0, 1'b1, 4'h0, 4'ha});
        @(negedge hclk);
        chk_val(rx_ready, 1'b0);
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_frames();
        t_cal();
        t_chan();
        t_cksum();
        t_proto();
        give_verdict();
    end
    // whole run needs under 500 cycles; allow forty times that
    initial
    begin
        #400000;
        err_count++;
        give_verdict();
    end
endmodule // ascii_config_command_parser_tb
